//--- rtl/cmirx_pkg.sv
package cmirx_pkg;
  // Loss count fixed inside the 96..224 window
  localparam int unsigned LOS_MIN_CYC = 96;
  localparam int unsigned LOS_MAX_CYC = 224;
  localparam logic [7:0] LOS_TRIP_CNT = 8'h80;
  // Reference divider ratio (155.52 / 19.44 = 8)
  localparam logic [3:0] REF_DIV_RATIO = 4'h8;
  // Register byte offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_IRQ = 4'h8;
  localparam logic [3:0] OFF_MASK = 4'hC;
  // Control field positions and reset value
  localparam int unsigned CTRL_CMI_BIT = 0;
  localparam int unsigned CTRL_SRC_BIT = 1;
  localparam int unsigned CTRL_BYP_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Interrupt bits: 0 loss set, 1 loss clear, 2 code violation
  localparam int unsigned IRQ_W = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cmirx_pkg

//--- rtl/cmirx_los_det.sv
`timescale 1ns/10ps
`default_nettype none
// Transition-absence and amplitude-loss detector
module cmirx_los_det (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Line observation
  input wire logic line_bit,
  input wire logic amp_low,
  input wire logic amp_high,
  // Loss status
  output logic loss
);
  logic line_prev_reg; // Previous line sample
  logic [7:0] quiet_reg; // Cycles without transition
  logic [7:0] amp_reg; // Cycles with amplitude low
  logic amp_loss_reg; // Latched amplitude loss

  // Previous sample for edge detect
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) line_prev_reg <= 1'b0;
    else line_prev_reg <= line_bit;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) quiet_reg <= 8'h00;
    else if (line_bit != line_prev_reg) quiet_reg <= 8'h00;
    else if (quiet_reg != cmirx_pkg::LOS_TRIP_CNT) quiet_reg <= quiet_reg + 8'h01;
  end

  // amplitude loss count; release above threshold
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      amp_reg <= 8'h00;
      amp_loss_reg <= 1'b0;
    end else if (amp_high) begin
      amp_reg <= 8'h00;
      amp_loss_reg <= 1'b0;
    end else if (amp_low) begin
      if (amp_reg == cmirx_pkg::LOS_TRIP_CNT) amp_loss_reg <= 1'b1;
      else amp_reg <= amp_reg + 8'h01;
    end else begin
      amp_reg <= 8'h00;
    end
  end

  assign loss = (quiet_reg == cmirx_pkg::LOS_TRIP_CNT) | amp_loss_reg;

  quiet_loss_a: assert property (@(posedge clk) disable iff (!resetn)
    (quiet_reg == cmirx_pkg::LOS_TRIP_CNT) |-> loss)
    else $error("quiet line did not raise loss");
  quiet_restart_a: assert property (@(posedge clk) disable iff (!resetn)
    (line_bit != line_prev_reg) |=> (quiet_reg == 8'h00))
    else $error("transition did not restart count");
  amp_release_a: assert property (@(posedge clk) disable iff (!resetn)
    amp_high |=> !amp_loss_reg)
    else $error("amplitude release ignored");
endmodule : cmirx_los_det
`default_nettype wire

//--- rtl/cmirx_decoder.sv
`timescale 1ns/10ps
`default_nettype none
// CMI half-bit pair decoder with violation check
module cmirx_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Half-bit pair of one symbol
  input wire logic sym_valid,
  input wire logic first_half,
  input wire logic second_half,
  // Decoded result
  output logic bit_out,
  output logic viol_out
);
  logic last_one_reg; // Level of the last one symbol
  logic zero_sym; // Symbol looks like a zero
  logic one_sym; // Symbol looks like a one

  // zero is low then high, one is steady
  assign zero_sym = !first_half && second_half;
  assign one_sym = first_half == second_half;

  // Track alternating one level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) last_one_reg <= 1'b0;
    else if (sym_valid && one_sym) last_one_reg <= first_half;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_out <= 1'b0;
      viol_out <= 1'b0;
    end else if (sym_valid) begin
      bit_out <= one_sym;
      viol_out <= !(zero_sym || one_sym) ||
                  (one_sym && first_half == last_one_reg);
    end
  end

  bad_zero_a: assert property (@(posedge clk) disable iff (!resetn)
    (sym_valid && first_half && !second_half) |=> viol_out)
    else $error("inverted zero not flagged");
  one_decode_a: assert property (@(posedge clk) disable iff (!resetn)
    (sym_valid && one_sym) |=> bit_out)
    else $error("steady symbol not decoded as one");
endmodule : cmirx_decoder
`default_nettype wire

//--- rtl/cmirx_top.sv
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module cmirx_top (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Line inputs, sampled at half-bit rate
  input wire logic optical_serial_in_pos,
  input wire logic optical_serial_in_neg,
  input wire logic equalized_coax_input,
  input wire logic reference_clock_in,
  // Comparator and detect inputs
  input wire logic amplitude_loss_input,
  input wire logic amplitude_threshold_ref,
  input wire logic optical_signal_detect,
  // Recovered outputs
  output logic recovered_clock_out,
  output logic recovered_data_out,
  output logic code_violation_flag,
  output logic signal_loss_indicator,
  output logic ref_div_out,
  output logic irq,
  // AXI4-Lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  ////////////////////////////////////////////////////////////////////
  logic [2:0] ctrl_reg; // Mode, source and bypass control
  logic [2:0] irq_reg; // Sticky events
  logic [2:0] mask_reg; // Interrupt enables
  logic [3:0] awaddr_reg; // Latched write address
  logic aw_have_reg; // Write address held
  logic [31:0] wdata_reg; // Latched write data
  logic w_have_reg; // Write data held
  logic cmi_mode; // CMI decoding on
  logic coax_sel; // Coax input chosen
  logic bypass; // PLL bypass test
  logic line_bit; // Selected line sample
  logic phase_reg; // Half-bit phase
  logic first_reg; // First half of symbol
  logic clk_out_reg; // Recovered clock level
  logic loss_det; // Detector loss
  logic use_ref; // Clock taken from reference
  logic use_ref_prev_reg; // Previous source state
  logic dec_bit; // Decoded bit
  logic dec_viol; // Decoded violation
  logic [3:0] div_reg; // Reference divider count
  logic ref_div_reg; // Divided clock level
  logic wr_fire; // Write executes
  logic [2:0] events; // Event pulses

  assign cmi_mode = ctrl_reg[cmirx_pkg::CTRL_CMI_BIT];
  assign coax_sel = ctrl_reg[cmirx_pkg::CTRL_SRC_BIT];
  assign bypass = ctrl_reg[cmirx_pkg::CTRL_BYP_BIT];

  ////////////////////////////////////////////////////////////////////
  // input routing; high picks coax
  assign line_bit = coax_sel ? equalized_coax_input
                  : (optical_serial_in_pos & ~optical_serial_in_neg);

  // Loss detection on the selected line
  cmirx_los_det u_los (
    .clk(clk),
    .resetn(resetn),
    .line_bit(line_bit),
    .amp_low(amplitude_loss_input),
    .amp_high(amplitude_threshold_ref),
    .loss(loss_det)
  );

  // signal detect in NRZ; bypass forces reference
  assign use_ref = loss_det | bypass |
                   (!cmi_mode && !optical_signal_detect);
  assign signal_loss_indicator = !use_ref;

  ////////////////////////////////////////////////////////////////////
  // Half-bit phase and first-half capture
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= 1'b0;
      first_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
      if (!phase_reg) first_reg <= line_bit;
    end
  end

  // Symbol decoder, one symbol per two samples
  cmirx_decoder u_dec (
    .clk(clk),
    .resetn(resetn),
    .sym_valid(phase_reg),
    .first_half(first_reg),
    .second_half(line_bit),
    .bit_out(dec_bit),
    .viol_out(dec_viol)
  );

  // Recovered clock: low half follows update; reference on loss, signal-detect drop in NRZ or bypass
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) clk_out_reg <= 1'b0;
    else if (use_ref) clk_out_reg <= reference_clock_in;
    else clk_out_reg <= ~phase_reg;
  end

  // data moves as clock falls while locked; CMI or NRZ
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      recovered_data_out <= 1'b0;
      code_violation_flag <= 1'b0;
    end else if (use_ref && !bypass) begin
      recovered_data_out <= 1'b0;
      code_violation_flag <= 1'b0;
    end else begin
      // Data moves only on phase_reg edges, where the clock output falls unless bypass takes the reference
      if (phase_reg) recovered_data_out <= cmi_mode ? dec_bit : line_bit;
      // flag only in CMI, dropped as soon as NRZ is chosen
      if (!cmi_mode) code_violation_flag <= 1'b0;
      else if (phase_reg) code_violation_flag <= dec_viol;
    end
  end
  assign recovered_clock_out = clk_out_reg;

  // divide clk by 16, the locked recovered clock rate over 8, to reference rate
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= 4'h0;
      ref_div_reg <= 1'b0;
    end else if (div_reg == cmirx_pkg::REF_DIV_RATIO - 4'h1) begin
      div_reg <= 4'h0;
      ref_div_reg <= ~ref_div_reg;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end
  assign ref_div_out = ref_div_reg;

  ////////////////////////////////////////////////////////////////////
  // Events: loss rise, loss fall, violation
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) use_ref_prev_reg <= 1'b0;
    else use_ref_prev_reg <= use_ref;
  end
  assign events = {code_violation_flag, use_ref_prev_reg & ~use_ref,
                   use_ref & ~use_ref_prev_reg};

  ////////////////////////////////////////////////////////////////////
  // AXI write channel capture
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_have_reg <= 1'b0;
      awaddr_reg <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (wr_fire) aw_have_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      w_have_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
    end else if (wr_fire) w_have_reg <= 1'b0;
  end

  // Write response
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cmirx_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_reg == cmirx_pkg::OFF_STATUS)
                     ? cmirx_pkg::RESP_SLVERR : cmirx_pkg::RESP_OKAY;
    end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
  end

  // Control and mask registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= cmirx_pkg::CTRL_RESET;
      mask_reg <= 3'h0;
    end else if (wr_fire && s_axi_wstrb[0]) begin
      if (awaddr_reg == cmirx_pkg::OFF_CTRL) ctrl_reg <= wdata_reg[2:0];
      if (awaddr_reg == cmirx_pkg::OFF_MASK) mask_reg <= wdata_reg[2:0];
    end
  end

  // Sticky events, set wins over write-one-to-clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) irq_reg <= 3'h0;
    else if (wr_fire && s_axi_wstrb[0] &&
             awaddr_reg == cmirx_pkg::OFF_IRQ)
      irq_reg <= (irq_reg & ~wdata_reg[2:0]) | events;
    else irq_reg <= irq_reg | events;
  end
  assign irq = |(irq_reg & mask_reg);

  // AXI read channel, answer one cycle after address
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= cmirx_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= cmirx_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        cmirx_pkg::OFF_CTRL: s_axi_rdata <= {29'h0, ctrl_reg};
        cmirx_pkg::OFF_STATUS: s_axi_rdata <= {29'h0, bypass, loss_det, use_ref};
        cmirx_pkg::OFF_IRQ: s_axi_rdata <= {29'h0, irq_reg};
        cmirx_pkg::OFF_MASK: s_axi_rdata <= {29'h0, mask_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= cmirx_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // bypass always selects reference
  bypass_ref_a: assert property (@(posedge clk) disable iff (!resetn)
    bypass |-> !signal_loss_indicator)
    else $error("bypass did not select reference");
  detect_ref_a: assert property (@(posedge clk) disable iff (!resetn)
    (!cmi_mode && !optical_signal_detect) |-> use_ref)
    else $error("signal detect loss ignored");
  // data changes only at falling recovered clock
  data_edge_a: assert property (@(posedge clk) disable iff (!resetn)
    (!use_ref && !$past(use_ref) && $changed(recovered_data_out))
      |-> !recovered_clock_out)
    else $error("data moved off the falling edge");
  nrz_noviol_a: assert property (@(posedge clk) disable iff (!resetn)
    (!cmi_mode && !$past(cmi_mode)) |-> !code_violation_flag)
    else $error("violation flag in NRZ mode");
  div_period_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(ref_div_reg) |-> ##8 $fell(ref_div_reg))
    else $error("divider period wrong");
  ref_clock_a: assert property (@(posedge clk)
    disable iff (!resetn)
    use_ref |=> (recovered_clock_out == $past(reference_clock_in)))
    else $error("clock not taken from reference");
  // data held low while on reference, except in bypass
  loss_data_a: assert property (@(posedge clk)
    disable iff (!resetn)
    (use_ref && !bypass) |=> !recovered_data_out)
    else $error("data not held low during loss");
  // Loss onset: locked to data, then on reference
  sequence loss_onset_s;
    !use_ref ##1 use_ref;
  endsequence
  // loss onset latches a sticky event
  loss_event_a: assert property (@(posedge clk)
    disable iff (!resetn)
    loss_onset_s |=> irq_reg[0])
    else $error("loss onset not latched");
  viol_sticky_a: assert property (@(posedge clk)
    disable iff (!resetn)
    code_violation_flag |=> irq_reg[2])
    else $error("violation not latched");
endmodule : cmirx_top
`default_nettype wire

//--- tb/cmirx_line_model.sv
`timescale 1ns/10ps
`default_nettype none
// Far-side line source standing in for the fiber receiver or coax equalizer
module cmirx_line_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Receiver half-bit phase marker
  input wire logic rco,
  // Traffic control from the bench
  input wire logic [1:0] mode,
  input wire logic bit_val,
  input wire logic bad_code,
  input wire logic use_coax,
  input wire logic amp_ok,
  input wire logic detect,
  // Line and status outputs
  output logic opt_pos,
  output logic opt_neg,
  output logic coax,
  output logic amp_low,
  output logic amp_high,
  output logic sig_det
);
  logic lvl_reg; // Current line level
  logic ones_reg; // Level of the last CMI one
  logic first; // Level set now is sampled as a first half-bit
  // Clock output high means the receiver's next sample is phase 0
  assign first = (rco === 1'b1);
  //////////////////////////////////////////////////////////////////////////
  // optical detect output
  assign sig_det = detect;
  // Amplitude comparator levels
  assign amp_low = !amp_ok;
  assign amp_high = amp_ok;
  // Selected path carries traffic, the other one stays quiet
  assign opt_pos = use_coax ? 1'b0 : lvl_reg;
  assign opt_neg = use_coax ? 1'b1 : !lvl_reg;
  assign coax = use_coax ? lvl_reg : 1'b0;
  // Symbol generator; mode 0 holds the line quiet
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lvl_reg <= 1'b0;
      ones_reg <= 1'b0;
    end else if (mode == 2'h1) begin
      // NRZ toggling pattern, one bit per two samples
      if (first) begin
        lvl_reg <= !lvl_reg;
      end
    end else if (mode == 2'h2) begin
      // CMI ones: steady level, alternating per one
      if (bit_val && first) begin
        lvl_reg <= !ones_reg;
        ones_reg <= !ones_reg;
      end else if (!bit_val) begin
        // CMI zero low then high, inverted when a bad code is asked
        lvl_reg <= first ? bad_code : !bad_code;
      end
    end
  end
endmodule : cmirx_line_model
`default_nettype wire

//--- tb/cmi_receive_los_control_test.sv
`timescale 1ns/10ps
`default_nettype none
// Bench for the receive line decoder and loss control
module cmi_receive_los_control_test;
  logic clk = 0, resetn = 0, opt_p, opt_n, coax, amp_lo, amp_hi, det;
  logic rco, rdo, cvf, sli, rdiv, irq, awr, wr, bv, arr, rv;
  logic [1:0] br, rr;
  logic [31:0] rd;
  logic [3:0] aw = 4'h0, ar = 4'h0;
  logic [31:0] wd = 32'h0;
  logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [1:0] mode = 2'h1; // Model traffic kind
  // idle stimulus: optical path chosen, detect held high
  logic bit_val = 0, bad = 0, use_coax = 0, amp_ok = 1, detect = 1;
  logic [2:0] ref_cnt = 3'h0; // Reference divider, toggles every 4 clk
  logic mon_on = 0, last_d = 0, last_c = 0;
  int mismatches = 0, tests_run = 0, cycles = 0;
  //////////////////////////////////////////////////////////////////////////
  // Clock and reference
  always #4 clk = ~clk;
  always @(posedge clk) ref_cnt <= ref_cnt + 3'h1;
  cmirx_line_model i_line (.clk(clk), .resetn(resetn), .rco(rco),
    .mode(mode), .bit_val(bit_val), .bad_code(bad), .use_coax(use_coax),
    .amp_ok(amp_ok), .detect(detect), .opt_pos(opt_p), .opt_neg(opt_n),
    .coax(coax), .amp_low(amp_lo), .amp_high(amp_hi), .sig_det(det));
  cmirx_top i_dut (.clk(clk), .resetn(resetn), .optical_serial_in_pos(opt_p),
    .optical_serial_in_neg(opt_n), .equalized_coax_input(coax),
    .reference_clock_in(ref_cnt[2]), .amplitude_loss_input(amp_lo),
    .amplitude_threshold_ref(amp_hi), .optical_signal_detect(det),
    .recovered_clock_out(rco), .recovered_data_out(rdo),
    .code_violation_flag(cvf), .signal_loss_indicator(sli),
    .ref_div_out(rdiv), .irq(irq), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ar),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre));
  //////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic check(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : check
  // AXI4-Lite write, address and data offered together
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
      input logic [1:0] er);
    logic done;
    done = 0;
    @(posedge clk);
    aw <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    while (!done) begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 0;
      if (wr === 1'b1) wv <= 0;
      if (bv === 1'b1) begin
        done = 1;
        bre <= 0;
        check("write response", 32'(er), 32'(br));
      end
    end
  endtask : axi_wr
  // AXI4-Lite read, compared under a mask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] e,
      input logic [31:0] m);
    logic done;
    done = 0;
    @(posedge clk);
    ar <= a;
    arv <= 1;
    rre <= 1;
    while (!done) begin
      @(posedge clk);
      if (arr === 1'b1) arv <= 0;
      if (rv === 1'b1) begin
        done = 1;
        rre <= 0;
        check("read data", e, rd & m);
      end
    end
  endtask : axi_rd
  // Wait for the loss indicator and check the delay window
  task automatic wait_sli(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (sli !== lvl && n <= hi) begin
      @(posedge clk);
      n++;
    end
    check("loss delay in window", 1, 32'(n >= lo && n <= hi));
  endtask : wait_sli
  // Count toggles of a clock output over 32 cycles
  task automatic count_tog(input logic sel, input int e);
    int n;
    logic p;
    n = 0;
    p = sel ? rdiv : rco;
    repeat (32) begin
      @(posedge clk);
      if ((sel ? rdiv : rco) !== p) n++;
      p = sel ? rdiv : rco;
    end
    check("clock toggles", 32'(e), 32'(n));
  endtask : count_tog
  //////////////////////////////////////////////////////////////////////////
  // data output changes only where the clock output falls
  always @(posedge clk) begin
    if (mon_on && rdo !== last_d) check("data edge", 1, 32'(last_c && !rco));
    last_d <= rdo;
    last_c <= rco;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1;
    // Reset values, read-only status refused
    axi_rd(cmirx_pkg::OFF_CTRL, 32'h0, 32'hFFFFFFFF);
    axi_rd(cmirx_pkg::OFF_MASK, 32'h0, 32'h7);
    axi_wr(cmirx_pkg::OFF_STATUS, 32'h7, cmirx_pkg::RESP_SLVERR);
    axi_rd(cmirx_pkg::OFF_STATUS, 32'h0, 32'h7);
    mon_on <= 1;
    count_tog(0, 32);
    count_tog(1, 4);
    // Short quiet gap then a full one
    mon_on <= 0;
    mode <= 2'h0;
    repeat (90) @(posedge clk);
    mode <= 2'h1;
    repeat (4) @(posedge clk);
    mode <= 2'h0;
    wait_sli(0, 96, 224);
    @(posedge clk);
    check("data during loss", 0, 32'(rdo));
    axi_rd(cmirx_pkg::OFF_STATUS, 32'h1, 32'h1);
    check("masked irq", 0, 32'(irq));
    axi_rd(cmirx_pkg::OFF_IRQ, 32'h1, 32'h1);
    axi_wr(cmirx_pkg::OFF_MASK, 32'h1, cmirx_pkg::RESP_OKAY);
    @(posedge clk);
    check("irq raised", 1, 32'(irq));
    axi_wr(cmirx_pkg::OFF_IRQ, 32'h1, cmirx_pkg::RESP_OKAY);
    @(posedge clk);
    check("irq cleared", 0, 32'(irq));
    mode <= 2'h1;
    wait_sli(1, 0, 8);
    axi_rd(cmirx_pkg::OFF_IRQ, 32'h2, 32'h2);
    // Optical signal-detect low in NRZ
    detect <= 0;
    wait_sli(0, 0, 4);
    detect <= 1;
    wait_sli(1, 0, 4);
    // Amplitude loss and release
    amp_ok <= 0;
    wait_sli(0, 96, 224);
    axi_rd(cmirx_pkg::OFF_STATUS, 32'h2, 32'h2);
    amp_ok <= 1;
    wait_sli(1, 0, 4);
    // Coax selected: quiet optics must not matter
    use_coax <= 1;
    axi_wr(cmirx_pkg::OFF_CTRL, 32'h2, cmirx_pkg::RESP_OKAY);
    repeat (300) @(posedge clk);
    check("coax traffic locked", 1, 32'(sli));
    use_coax <= 0;
    wait_sli(0, 96, 224);
    axi_wr(cmirx_pkg::OFF_CTRL, 32'h0, cmirx_pkg::RESP_OKAY);
    wait_sli(1, 0, 8);
    // CMI zeros, then ones, then bad zeros
    mode <= 2'h2;
    axi_wr(cmirx_pkg::OFF_CTRL, 32'h1, cmirx_pkg::RESP_OKAY);
    repeat (40) @(posedge clk);
    mon_on <= 1;
    check("cmi zero", 0, 32'(rdo));
    check("clean zero flag", 0, 32'(cvf));
    bit_val <= 1;
    repeat (20) @(posedge clk);
    axi_wr(cmirx_pkg::OFF_IRQ, 32'h7, cmirx_pkg::RESP_OKAY);
    repeat (20) @(posedge clk);
    check("cmi one", 1, 32'(rdo));
    axi_rd(cmirx_pkg::OFF_IRQ, 32'h0, 32'h4);
    bit_val <= 0;
    bad <= 1;
    repeat (20) @(posedge clk);
    check("violation flag", 1, 32'(cvf));
    axi_rd(cmirx_pkg::OFF_IRQ, 32'h4, 32'h4);
    bad <= 0;
    // Bypass takes the recovered clock output from the reference clock
    mon_on <= 0;
    axi_wr(cmirx_pkg::OFF_CTRL, 32'h4, cmirx_pkg::RESP_OKAY);
    repeat (8) @(posedge clk);
    axi_rd(cmirx_pkg::OFF_STATUS, 32'h5, 32'h5);
    count_tog(0, 8);
    end_of_test();
  end
endmodule : cmi_receive_los_control_test
`default_nettype wire
